/* File: core/iwwdg_top.sv */
// Independent window watchdog with APB register access
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "iwwdg_defs.svh"


module iwwdg_top
  import iwwdg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  input  wire logic           clk_en,
  // APB slave
  input  wire iwwdg_apb_req_t apb_req,
  output iwwdg_apb_rsp_t      apb_rsp,
  // Slow oscillator and option strap
  input  wire logic           slow_internal_osc,
  input  wire logic           hw_autostart_opt,
  // Debug control
  input  wire logic           debug_halt,
  input  wire logic           debug_freeze_bit,
  // System reset request
  output logic                wdg_reset_pulse
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        setup_phase, access_phase, wr_take;
  logic        addr_hit, size_ok, lo_half;
  logic [15:0] cmd_code;

  assign setup_phase  = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable & clk_en;
  assign addr_hit     = (apb_req.paddr[1:0] == 2'b00) &
                        (apb_req.paddr <= `IWWDG_OFS_WINDOW);
  assign size_ok      = ~apb_req.pwrite | (apb_req.pstrb == 4'hF) |
                        (apb_req.pstrb == 4'h3) | (apb_req.pstrb == 4'hC);
  assign lo_half      = apb_req.pstrb[1] & apb_req.pstrb[0];
  assign wr_take      = access_phase & apb_req.pwrite & addr_hit & size_ok & lo_half;
  // command lives in the low half-word
  assign cmd_code     = apb_req.pwdata[`IWWDG_CMD_MSB:0];

  // ----------------------------------------------------------------
  // Bus-side registers
  // ----------------------------------------------------------------
  logic [2:0]  div_sel_reg,  div_sel_next;
  logic [11:0] reload_reg,   reload_next;
  logic [11:0] window_reg,   window_next;
  logic        unlocked_reg, unlocked_next;
  logic        start_reg,    start_next;
  logic        strap_done_reg, strap_done_next;
  logic [2:0]  post_req, pend_vec, apply_vec;
  logic [31:0] prdata_reg,   prdata_next;
  logic        cmd_reload;
  logic        wr_cmd;
  assign wr_cmd     = wr_take & (apb_req.paddr == `IWWDG_OFS_COMMAND);
  assign cmd_reload = wr_cmd & (cmd_code == `IWWDG_CMD_RELOAD);

  always_comb
  begin
    div_sel_next    = div_sel_reg;
    reload_next     = reload_reg;
    window_next     = window_reg;
    unlocked_next   = unlocked_reg;
    start_next      = start_reg;
    strap_done_next = 1'b1;
    post_req        = 3'b000;
    prdata_next     = prdata_reg;
    // option strap caught once after reset release
    if (!strap_done_reg && hw_autostart_opt)
      start_next = 1'b1;
    if (wr_cmd)
    begin
      unlocked_next = (cmd_code == `IWWDG_CMD_UNLOCK);
      if (cmd_code == `IWWDG_CMD_START)
        start_next = 1'b1;
    end
    if (wr_take && unlocked_reg)
    begin
      case (apb_req.paddr)
        `IWWDG_OFS_PRESCALE:
        begin
          div_sel_next = apb_req.pwdata[`IWWDG_DIV_MSB:0];
          post_req[0]  = 1'b1;
        end
        `IWWDG_OFS_RELOAD:
        begin
          reload_next = apb_req.pwdata[`IWWDG_CNT_MSB:0];
          post_req[1] = 1'b1;
        end
        `IWWDG_OFS_WINDOW:
        begin
          window_next = apb_req.pwdata[`IWWDG_CNT_MSB:0];
          post_req[2] = 1'b1;
        end
        default: post_req = 3'b000;
      endcase
    end
    if (setup_phase)
    begin
      prdata_next = 32'h0000_0000;
      case (apb_req.paddr)
        `IWWDG_OFS_PRESCALE: prdata_next[2:0]  = div_sel_reg;
        `IWWDG_OFS_RELOAD:   prdata_next[11:0] = reload_reg;
        `IWWDG_OFS_WINDOW:   prdata_next[11:0] = window_reg;
        `IWWDG_OFS_STATUS:   prdata_next[2:0]  = pend_vec;
        default:             prdata_next       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      div_sel_reg    <= `IWWDG_RST_DIV;
      reload_reg     <= `IWWDG_RST_RELOAD;
      window_reg     <= `IWWDG_RST_WINDOW;
      unlocked_reg   <= 1'b0;
      start_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
      prdata_reg     <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      div_sel_reg    <= div_sel_next;
      reload_reg     <= reload_next;
      window_reg     <= window_next;
      unlocked_reg   <= unlocked_next;
      start_reg      <= start_next;
      strap_done_reg <= strap_done_next;
      prdata_reg     <= prdata_next;
    end
  end

  // Zero wait states; read data was captured in the setup cycle
  assign apb_rsp = '{prdata:  prdata_reg,
                     pready:  access_phase,
                     pslverr: access_phase & ~(addr_hit & size_ok)};

  // ----------------------------------------------------------------
  // Slow oscillator edge
  // ----------------------------------------------------------------
  logic osc_q_reg, osc_edge, halt_freeze;

  // osc is its own time base; only its rising edges advance state
  assign osc_edge = slow_internal_osc & ~osc_q_reg;
  // freeze only when halted and the freeze bit is set
  assign halt_freeze = debug_halt & debug_freeze_bit;

  // ----------------------------------------------------------------
  // Update carry into the osc domain, one channel each for prescale, reload and window
  // ----------------------------------------------------------------
  generate
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_pend
      logic       pend_reg, pend_next;
      logic [1:0] cnt_reg,  cnt_next;
      logic       apply;
      always_comb
      begin
        pend_next = pend_reg;
        cnt_next  = cnt_reg;
        apply     = 1'b0;
        // pending until enough osc edges have passed
        if (post_req[gi])
        begin
          pend_next = 1'b1;
          cnt_next  = 2'h0;
        end
        else if (pend_reg && osc_edge)
        begin
          if (cnt_reg == `IWWDG_SYNC_EDGES - 2'h1)
          begin
            pend_next = 1'b0;
            apply     = 1'b1;
          end
          else
            cnt_next = cnt_reg + 2'h1;
        end
      end

      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
        begin
          pend_reg <= 1'b0;
          cnt_reg  <= 2'h0;
        end
        else if (clk_en)
        begin
          pend_reg <= pend_next;
          cnt_reg  <= cnt_next;
        end
      end
      assign pend_vec[gi]  = pend_reg;
      assign apply_vec[gi] = apply;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Osc-domain working copies and counter
  // ----------------------------------------------------------------
  iwwdg_state_t state_reg, state_next;
  logic [2:0]  div_act_reg, div_act_next;
  logic [11:0] rld_act_reg, rld_act_next;
  logic [11:0] wnd_act_reg, wnd_act_next;
  logic [7:0]  pre_reg,     pre_next;
  logic [11:0] cnt_reg,     cnt_next;
  logic [7:0]  pre_last;
  logic        reload_now, fire;
  // divide ratio from the selection code
  always_comb
  begin
    case (div_act_reg)
      3'h0:    pre_last = 8'h03;
      3'h1:    pre_last = 8'h07;
      3'h2:    pre_last = 8'h0F;
      3'h3:    pre_last = 8'h1F;
      3'h4:    pre_last = 8'h3F;
      3'h5:    pre_last = 8'h7F;
      default: pre_last = `IWWDG_DIV_LAST_MAX;
    endcase
  end
  always_comb
  begin
    state_next   = state_reg;
    div_act_next = apply_vec[0] ? div_sel_reg : div_act_reg;
    rld_act_next = apply_vec[1] ? reload_reg  : rld_act_reg;
    wnd_act_next = apply_vec[2] ? window_reg  : wnd_act_reg;
    pre_next     = pre_reg;
    cnt_next     = cnt_reg;
    fire         = 1'b0;
    // reload command, window change also reloads
    reload_now   = cmd_reload | apply_vec[2];
    case (state_reg)
      IWWDG_ST_IDLE:
      begin
        if (reload_now)
          cnt_next = rld_act_reg;
        if (start_reg)
          state_next = IWWDG_ST_RUN;
      end
      IWWDG_ST_RUN:
      begin
        // refresh above the window is a fault
        if (cmd_reload && (cnt_reg > wnd_act_reg))
          fire = 1'b1;
        else if (reload_now)
        begin
          cnt_next = rld_act_reg;
          pre_next = 8'h00;
        end
        // prescaler then counter, one step per tick
        else if (osc_edge && !halt_freeze)
        begin
          if (pre_reg >= pre_last)
          begin
            pre_next = 8'h00;
            if (cnt_reg == `IWWDG_CNT_ZERO)
              fire = 1'b1;
            else
              cnt_next = cnt_reg - 12'h001;
          end
          else
            pre_next = pre_reg + 8'h01;
        end
        if (fire)
        begin
          state_next = IWWDG_ST_FIRE;
          cnt_next   = rld_act_reg;
          pre_next   = 8'h00;
        end
      end
      // Reset controller is expected to reset us; resume if it does not
      IWWDG_ST_FIRE: state_next = IWWDG_ST_RUN;
      default:       state_next = IWWDG_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_reg   <= IWWDG_ST_IDLE;
      div_act_reg <= `IWWDG_RST_DIV;
      rld_act_reg <= `IWWDG_RST_RELOAD;
      wnd_act_reg <= `IWWDG_RST_WINDOW;
      pre_reg     <= 8'h00;
      cnt_reg     <= `IWWDG_RST_RELOAD;
      // Track the osc level through reset so release shows no false edge
      osc_q_reg   <= slow_internal_osc;
    end
    else if (clk_en)
    begin
      state_reg   <= state_next;
      div_act_reg <= div_act_next;
      rld_act_reg <= rld_act_next;
      wnd_act_reg <= wnd_act_next;
      pre_reg     <= pre_next;
      cnt_reg     <= cnt_next;
      osc_q_reg   <= slow_internal_osc;
    end
  end

  assign wdg_reset_pulse = (state_reg == IWWDG_ST_FIRE);

endmodule : iwwdg_top

/* File: core/iwwdg_defs.svh */
// Offsets, field layouts, reset values and timing counts of the independent watchdog
`ifndef IWWDG_DEFS_SVH
`define IWWDG_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IWWDG_OFS_COMMAND   5'h00
`define IWWDG_OFS_PRESCALE  5'h04
`define IWWDG_OFS_RELOAD    5'h08
`define IWWDG_OFS_STATUS    5'h0C
`define IWWDG_OFS_WINDOW    5'h10

// ----------------------------------------------------------------
// Command codes and fields
// ----------------------------------------------------------------
`define IWWDG_CMD_UNLOCK    16'h5555
`define IWWDG_CMD_START     16'hCCCC
`define IWWDG_CMD_RELOAD    16'hAAAA
`define IWWDG_CMD_MSB       15
`define IWWDG_DIV_MSB       2
`define IWWDG_CNT_MSB       11

// ----------------------------------------------------------------
// Reset values and counter zero
// ----------------------------------------------------------------
`define IWWDG_RST_DIV       3'h0
`define IWWDG_RST_RELOAD    12'hFFF
`define IWWDG_RST_WINDOW    12'hFFF
`define IWWDG_CNT_ZERO      12'h000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Nominal oscillator rate, for reference only: the osc arrives as a level
`define IWWDG_OSC_KHZ       40
// Slow-oscillator edges needed to carry a config update across
`define IWWDG_SYNC_EDGES    2'h2
`define IWWDG_DIV_LAST_MAX  8'hFF

`endif

/* File: core/iwwdg_pkg.sv */
// Types shared by the independent watchdog
package iwwdg_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [4:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } iwwdg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } iwwdg_apb_rsp_t;

  typedef enum logic [2:0] {
    IWWDG_ST_IDLE  = 3'b001,
    IWWDG_ST_RUN   = 3'b010,
    IWWDG_ST_FIRE  = 3'b100
  } iwwdg_state_t;

endpackage : iwwdg_pkg

/* File: verification/iwwdg_monitor.sv */
// Port-level assertions for the independent watchdog
`timescale 1ns/1ps
`include "iwwdg_defs.svh"

module iwwdg_monitor
  import iwwdg_pkg::*;
(
  // Clock and reset
  input wire logic           sys_clk,
  input wire logic           rstn,
  input wire logic           clk_en,
  // Bus
  input wire iwwdg_apb_req_t apb_req,
  input wire iwwdg_apb_rsp_t apb_rsp,
  // Watchdog side
  input wire logic           slow_internal_osc,
  input wire logic           hw_autostart_opt,
  input wire logic           debug_halt,
  input wire logic           debug_freeze_bit,
  input wire logic           wdg_reset_pulse
);
  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic acc;
  logic rd;
  logic mapped;
  logic strb_ok;

  assign acc     = apb_req.psel && apb_req.penable && clk_en;
  assign rd      = acc && !apb_req.pwrite;
  assign mapped  = apb_req.paddr inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
  assign strb_ok = apb_req.pstrb inside {4'hF, 4'h3, 4'hC};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ready_now: assert property (acc |-> apb_rsp.pready)
    else $error("pready missing in access phase");
  a_ready_idle: assert property (!apb_req.penable |-> !apb_rsp.pready)
    else $error("pready outside access phase");
  a_bad_addr: assert property (acc && !mapped |-> apb_rsp.pslverr
    && (apb_req.pwrite || apb_rsp.prdata == 32'h0))
    else $error("unmapped access not refused");
  a_bad_strobe: assert property (acc && apb_req.pwrite && !strb_ok |-> apb_rsp.pslverr)
    else $error("illegal strobe not refused");
  a_good_access: assert property (
    acc && mapped && (!apb_req.pwrite || strb_ok) |-> !apb_rsp.pslverr)
    else $error("legal access refused");
  a_cmd_read: assert property (
    rd && apb_req.paddr == `IWWDG_OFS_COMMAND |-> apb_rsp.prdata == 32'h0)
    else $error("command register readable");
  a_count_upper: assert property (
    rd && apb_req.paddr inside {`IWWDG_OFS_RELOAD, `IWWDG_OFS_WINDOW}
    |-> apb_rsp.prdata[31:12] == 20'h0)
    else $error("count register upper bits set");
  a_status_upper: assert property (
    rd && apb_req.paddr == `IWWDG_OFS_STATUS |-> apb_rsp.prdata[31:3] == 29'h0)
    else $error("status upper bits set");
  a_pulse_once: assert property (wdg_reset_pulse |=> !wdg_reset_pulse)
    else $error("reset request longer than one cycle");
  // Four quiet cycles let any pulse already launched drain first
  a_frozen_quiet: assert property (
    (debug_halt && debug_freeze_bit && !apb_req.psel)[*4] |-> !wdg_reset_pulse)
    else $error("reset request while frozen");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> !wdg_reset_pulse)
    else $error("reset request during reset");
endmodule : iwwdg_monitor

bind iwwdg_top iwwdg_monitor i_iwwdg_monitor (
  .sys_clk           (sys_clk),
  .rstn              (rstn),
  .clk_en            (clk_en),
  .apb_req           (apb_req),
  .apb_rsp           (apb_rsp),
  .slow_internal_osc (slow_internal_osc),
  .hw_autostart_opt  (hw_autostart_opt),
  .debug_halt        (debug_halt),
  .debug_freeze_bit  (debug_freeze_bit),
  .wdg_reset_pulse   (wdg_reset_pulse)
);

/* File: verification/iwwdg_osc_model.sv */
// Free-running slow oscillator source for the watchdog
`timescale 1ns/1ps

module iwwdg_osc_model #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic sys_clk,
  // Oscillator level
  output logic     osc
);
  int cnt = 0;

  initial osc = 1'b0;

  // Runs free, level synced to sys_clk
  always @(posedge sys_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      osc <= !osc;
  end
endmodule : iwwdg_osc_model

/* File: verification/tb_top.sv */
// Register-level testbench for the independent watchdog
`timescale 1ns/1ps
`include "iwwdg_defs.svh"

module tb_top
  import iwwdg_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           rstn    = 1'b0;
  logic           opt     = 1'b0;
  logic           halt    = 1'b0;
  logic           frz     = 1'b0;
  iwwdg_apb_req_t req     = '0;
  iwwdg_apb_rsp_t rsp;
  logic           osc;
  logic           osc_q   = 1'b0;
  logic           pulse;
  logic [3:0]     strb_v  = 4'hF;
  logic [31:0]    r;
  logic           e;
  logic           got;
  int             err_count = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  int             edges = 0;
  int             pulses = 0;
  int             p0;
  int             e0;
  int             ed;
  int             rt;

  always #4 sys_clk = ~sys_clk;

  iwwdg_top i_iwwdg_top (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .apb_req(req),
    .apb_rsp(rsp), .slow_internal_osc(osc), .hw_autostart_opt(opt), .debug_halt(halt),
    .debug_freeze_bit(frz), .wdg_reset_pulse(pulse));
  iwwdg_osc_model i_iwwdg_osc_model (.sys_clk(sys_clk), .osc(osc));

  // ------------------------------------------------------------
  // Event counters and timeout
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    osc_q <= osc;
    edges <= edges + ((osc === 1'b1 && osc_q === 1'b0) ? 1 : 0);
    pulses <= pulses + ((pulse === 1'b1) ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task conclude;
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d, strb_v};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    // Only the bench timeout ends this wait
    while (rsp.pready !== 1'b1)
      @(posedge sys_clk);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge sys_clk);
  endtask : apb

  task wr(input logic [4:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask : wr

  task rdc(input logic [4:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rdc

  // Pending bits must clear before the next change
  task settle;
    r = 32'h1;
    while (r !== 32'h0)
      apb(1'b0, `IWWDG_OFS_STATUS, 32'h0);
  endtask : settle

  task cfg(input logic [2:0] code);
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_UNLOCK);
    wr(`IWWDG_OFS_PRESCALE, {13'h0, code});
    strb_v = 4'h3;
    wr(`IWWDG_OFS_RELOAD, 16'h1);
    strb_v = 4'hF;
    rdc(`IWWDG_OFS_STATUS, 32'h3);
    settle();
  endtask : cfg

  task mark;
    p0 = pulses;
    e0 = edges;
  endtask : mark

  task catch(input int lim);
    int c;
    c = 0;
    while (pulses == p0 && c < lim)
    begin
      @(posedge sys_clk);
      c++;
    end
    got = (pulses != p0);
    ed = edges - e0;
  endtask : catch

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdc(`IWWDG_OFS_PRESCALE, 32'h0);
    rdc(`IWWDG_OFS_RELOAD, 32'hFFF);
    rdc(`IWWDG_OFS_STATUS, 32'h0);
    rdc(`IWWDG_OFS_WINDOW, 32'hFFF);
    rdc(`IWWDG_OFS_COMMAND, 32'h0);
    apb(1'b0, 5'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(`IWWDG_OFS_RELOAD, 16'h5);
    rdc(`IWWDG_OFS_RELOAD, 32'hFFF);
    // Non-decreasing ratios, so a live prescaler count never overshoots a new terminal
    for (int c = 0; c < 8; c++)
    begin
      cfg(c[2:0]);
      wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_RELOAD);
      if (c == 0)
        wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_START);
      mark();
      catch(8000);
      rt = 4 << ((c > 5) ? 6 : c);
      chk({31'h0, got && ed > rt && ed <= 3 * rt}, 32'h1);
    end
    halt <= 1'b1;
    frz <= 1'b1;
    mark();
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_RELOAD);
    catch(1600);
    chk({31'h0, got}, 32'h0);
    frz <= 1'b0;
    catch(8000);
    chk({31'h0, got}, 32'h1);
    halt <= 1'b0;
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_UNLOCK);
    wr(`IWWDG_OFS_RELOAD, 16'h100);
    wr(`IWWDG_OFS_COMMAND, 16'h0);
    wr(`IWWDG_OFS_RELOAD, 16'h7);
    settle();
    rdc(`IWWDG_OFS_RELOAD, 32'h100);
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_UNLOCK);
    wr(`IWWDG_OFS_WINDOW, 16'h10);
    settle();
    rdc(`IWWDG_OFS_WINDOW, 32'h10);
    mark();
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_RELOAD);
    catch(8);
    chk({31'h0, got}, 32'h1);
    opt <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    cfg(3'h0);
    // over three osc periods pass after this reload before the run ends
    wr(`IWWDG_OFS_COMMAND, `IWWDG_CMD_RELOAD);
    mark();
    catch(2000);
    chk({31'h0, got}, 32'h1);
    conclude();
  end
endmodule : tb_top
